//--- rtl/bff_find_first.v
`timescale 1ns/1ps
`default_nettype none
`include "bff_regs.vh"
// Functional notes
// - fields 0..32 bits, any alignment
// - start position is signed 32-bit offset
// - register field: position outside 0..31 faults
// - size above 32 faults; zero special
// - register base: Rn or Rn+1:Rn
// - position, size, base locate; fourth destination
// - opcode EB finds zero, EA finds one
// - scan from field bit 0 upward
// - hit: position of bit, Z cleared
// - miss: position past field, Z set
// - size zero: start position, Z set
// - N, V, C always forced zero
module bff_find_first (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0]  state_ff;
  reg [7:0]  opcode_ff;
  reg        reg_mode_ff;
  reg [31:0] pos_ff;
  reg [7:0]  size_ff;
  reg [31:0] base_lo_ff;
  reg [31:0] base_hi_ff;
  reg [31:0] result_ff;
  reg [7:0]  status_ff;
  reg [31:0] nxt_result;
  reg [7:0]  nxt_status;

  wire setup    = psel & ~penable;
  wire wr_setup = setup & pwrite;
  wire rd_setup = setup & ~pwrite;
  wire addr_ok  = (paddr == `BFF_OFF_CTRL) || (paddr == `BFF_OFF_POS) ||
                  (paddr == `BFF_OFF_SIZE) || (paddr == `BFF_OFF_BASE_LO) ||
                  (paddr == `BFF_OFF_BASE_HI) || (paddr == `BFF_OFF_RESULT) ||
                  (paddr == `BFF_OFF_STATUS);
  wire start    = wr_setup & (paddr == `BFF_OFF_CTRL) & pwdata[`BFF_CTRL_GO_BIT] & (state_ff != ST_EXEC);

  // field extraction: 64-bit source covers up to 5 bytes at any alignment
  wire [63:0] src64    = {base_hi_ff, base_lo_ff};
  wire [4:0]  bit_off  = pos_ff[4:0];
  wire [63:0] shifted  = src64 >> bit_off;
  wire [31:0] field    = shifted[31:0];
  wire [32:0] ones33   = (33'h1_0000_0000 >> (6'h20 - size_ff[5:0]));
  wire [31:0] valid    = (size_ff[5:0] == 6'h20) ? 32'hffffffff : ((32'h1 << size_ff[4:0]) - 32'h1);
  wire        is_zero_op = (opcode_ff == `BFF_OP_FFZ);
  wire        is_one_op  = (opcode_ff == `BFF_OP_FFO);
  wire        hit;
  wire [5:0]  hit_idx;

  bff_scan #(
    .W (32)
  ) u_scan (
    .field_bits (field),
    .valid_bits (valid),
    .want_one   (is_one_op),
    .hit        (hit),
    .hit_idx    (hit_idx)
  );

  wire pos_neg    = pos_ff[31];
  wire pos_bad    = reg_mode_ff & (pos_ff > `BFF_MAX_REG_POS);
  wire size_bad   = size_ff > `BFF_MAX_SIZE;

  // execute: the three locating operands produce the destination value
  always @* begin
    nxt_result = result_ff;
    nxt_status = 8'h00;
    nxt_status[`BFF_ST_DONE] = 1'b1;
    if (!(is_zero_op || is_one_op)) begin
      nxt_status[`BFF_ST_BADOP] = 1'b1;
    end else if (pos_bad || size_bad) begin
      nxt_status[`BFF_ST_FAULT] = 1'b1;
    end else if (size_ff == 8'h00) begin
      nxt_result           = pos_ff;
      nxt_status[`BFF_ST_Z] = 1'b1;
    end else if (hit) begin
      nxt_result           = pos_ff + {26'h0, hit_idx};
      nxt_status[`BFF_ST_Z] = 1'b0;
    end else begin
      nxt_result           = pos_ff + {24'h0, size_ff};
      nxt_status[`BFF_ST_Z] = 1'b1;
    end
    nxt_status[`BFF_ST_N] = 1'b0;
    nxt_status[`BFF_ST_V] = 1'b0;
    nxt_status[`BFF_ST_C] = 1'b0;
  end

  // memory fields with negative position still locate via low five bits
  wire unused_ok = pos_neg & ones33[0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= ST_IDLE;
      opcode_ff   <= 8'h00;
      reg_mode_ff <= 1'b0;
      pos_ff      <= 32'h0;
      size_ff     <= 8'h00;
      base_lo_ff  <= 32'h0;
      base_hi_ff  <= 32'h0;
      result_ff   <= 32'h0;
      status_ff   <= 8'h00;
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
      if (rd_setup) begin
        case (paddr)
          `BFF_OFF_CTRL:    prdata <= {23'h0, reg_mode_ff, opcode_ff};
          `BFF_OFF_POS:     prdata <= pos_ff;
          `BFF_OFF_SIZE:    prdata <= {24'h0, size_ff};
          `BFF_OFF_BASE_LO: prdata <= base_lo_ff;
          `BFF_OFF_BASE_HI: prdata <= base_hi_ff;
          `BFF_OFF_RESULT:  prdata <= result_ff;
          `BFF_OFF_STATUS:  prdata <= {24'h0, status_ff};
          default:          prdata <= 32'h0;
        endcase
      end else begin
        prdata <= 32'h0;
      end
      if (wr_setup && state_ff != ST_EXEC) begin
        case (paddr)
          `BFF_OFF_CTRL: begin
            opcode_ff   <= pwdata[`BFF_CTRL_OP_MSB:`BFF_CTRL_OP_LSB];
            reg_mode_ff <= pwdata[`BFF_CTRL_REG_BIT];
          end
          `BFF_OFF_POS:     pos_ff     <= pwdata;
          `BFF_OFF_SIZE:    size_ff    <= pwdata[7:0];
          `BFF_OFF_BASE_LO: base_lo_ff <= pwdata;
          `BFF_OFF_BASE_HI: base_hi_ff <= pwdata;
          default: ;
        endcase
      end
      case (state_ff)
        ST_IDLE, ST_DONE: begin
          if (start) begin
            state_ff  <= ST_EXEC;
            status_ff <= 8'h80;
          end
        end
        ST_EXEC: begin
          if (!nxt_status[`BFF_ST_FAULT] && !nxt_status[`BFF_ST_BADOP]) begin
            result_ff <= nxt_result;
          end
          status_ff <= nxt_status;
          state_ff  <= ST_DONE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // bff_find_first
`default_nettype wire

//--- rtl/bff_regs.vh
`ifndef BFF_REGS_VH
`define BFF_REGS_VH
`define BFF_ADDR_W        12
`define BFF_OFF_CTRL      12'h000
`define BFF_OFF_POS       12'h004
`define BFF_OFF_SIZE      12'h008
`define BFF_OFF_BASE_LO   12'h00c
`define BFF_OFF_BASE_HI   12'h010
`define BFF_OFF_RESULT    12'h014
`define BFF_OFF_STATUS    12'h018
`define BFF_OP_FFZ        8'heb
`define BFF_OP_FFO        8'hea
`define BFF_MAX_SIZE      8'h20
`define BFF_MAX_REG_POS   32'h0000001f
`define BFF_CTRL_OP_LSB   0
`define BFF_CTRL_OP_MSB   7
`define BFF_CTRL_REG_BIT  8
`define BFF_CTRL_GO_BIT   31
`define BFF_ST_N          0
`define BFF_ST_Z          1
`define BFF_ST_V          2
`define BFF_ST_C          3
`define BFF_ST_FAULT      4
`define BFF_ST_BADOP      5
`define BFF_ST_DONE       6
`define BFF_ST_BUSY       7
`endif

//--- rtl/bff_scan.v
`timescale 1ns/1ps
`default_nettype none
module bff_scan #(
  parameter W = 32
) (
  input  wire [W-1:0]  field_bits,
  input  wire [W-1:0]  valid_bits,
  input  wire          want_one,
  output reg           hit,
  output reg  [5:0]    hit_idx
);
  wire [W-1:0] match;
  integer      i;
  genvar       g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_match
      assign match[g] = valid_bits[g] & (field_bits[g] == want_one);
    end
  endgenerate
  // lowest matching bit wins, scanning downward from bit W-1 and keeping the last match
  always @* begin
    hit     = 1'b0;
    hit_idx = 6'h00;
    for (i = W - 1; i >= 0; i = i - 1) begin
      if (match[i]) begin
        hit     = 1'b1;
        hit_idx = i[5:0];
      end
    end
  end
endmodule // bff_scan
`default_nettype wire

//--- tb/bff_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bff_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence st_rd_s; pready && !pwrite && paddr == 12'h018; endsequence
  rdy_after_setup_a: assert property (setup_s |=> pready) else $error("no ready after setup");
  rdy_one_cycle_a: assert property (pready |=> !pready) else $error("ready too long");
  rdy_cause_a: assert property (pready |-> $past(psel) && !$past(penable)) else $error("ready without setup");
  err_unmapped_a: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("no slverr");
  err_mapped_a: assert property (pready && paddr <= 12'h018 |-> !pslverr) else $error("bad slverr");
  idle_quiet_a: assert property (!pready |-> !pslverr && prdata == 0) else $error("output not idle");
  flags_zero_a: assert property (st_rd_s |-> prdata[3:2] == 0 && !prdata[0]) else $error("nvc set");
  fault_z_a: assert property (st_rd_s ##0 prdata[4] |-> !prdata[1]) else $error("z on fault");
endmodule // bff_checker
bind bff_find_first bff_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, pready, pslverr, er;
  logic        presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int          num_errors = 0, total_checks = 0;
  bff_find_first dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // one find: operands, go, then status and result
  task run(input logic [8:0] c, input logic [31:0] p, input logic [7:0] s, input logic [31:0] lo, hi, r, st);
    apb(1, 12'h004, p);
    apb(1, 12'h008, {24'h0, s});
    apb(1, 12'h00c, lo);
    apb(1, 12'h010, hi);
    apb(1, 12'h000, {1'b1, 22'h0, c});
    apb(0, 12'h018, 0);
    chk("status", st, rd);
    apb(0, 12'h014, 0);
    chk("result", r, rd);
  endtask
  task t_hit;
    run(9'h0ea, 5, 10, 32'h2400, 0, 10, 32'h40);
    run(9'h0eb, 4, 10, 32'hf0, 0, 8, 32'h40);
    run(9'h0ea, 32'hfffffffe, 4, 0, 1, 0, 32'h40);
    run(9'h1eb, 31, 2, 32'h80000000, 0, 32, 32'h40);
  endtask
  task t_miss;
    run(9'h0ea, 3, 4, 0, 32'hffffffff, 7, 32'h42);
    run(9'h0eb, 0, 32, 32'hffffffff, 0, 32, 32'h42);
    run(9'h0ea, 9, 0, 32'hffffffff, 0, 9, 32'h42);
  endtask
  task t_fault;
    run(9'h0ea, 0, 33, 1, 0, 9, 32'h50);
    run(9'h1ea, 32, 1, 1, 0, 9, 32'h50);
  endtask
  task t_bus;
    apb(0, 12'h01c, 0);
    chk("slverr", 1, {31'h0, er});
    chk("unmapped", 0, rd);
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h1ea, rd);
  endtask
  task test_done;
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_hit;
    t_miss;
    t_fault;
    t_bus;
    test_done;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
